/* File: uasp_pkg.sv */
// Overview of operation
// - full duplex; each direction has a holding register apart from its shift register.
// - frames carry 7 or 8 data bits (word_len_8, reset 1) and one stop bit.
// - parity_en set adds a parity bit on transmit and checks it on receive.
// - parity_odd_sel selects odd parity when 1, even when 0, both directions.
// - clk_src_crystal_sel (format bit 7, reset 0) picks the crystal as baud source.
// - otherwise ext_clock_sel chooses between the RC oscillator and the external clock.
// - ten programmable rates from 300 to 153600 baud.
// - RC divided by 16 at baud_sel 111, halving per step; external divided by 32.
// - baud_sel sits in control bits 2..0 and resets to 101.
// - receive only while rx_en, transmit only while tx_en; both reset to 0.
// - rx_pad_invert inverts the receive pad, tx_pad_invert the transmit pad.
// - echo_en routes received line straight back onto the transmit line.
// - tx_holding_full sets on holding write, clears when the byte enters the shifter.
// - rx_holding_full sets on store, clears on data read; rx_active shows reception.
// - start, parity and frame errors show on receive status bits 5, 4, 3.
// - overrun_err holds until software writes anything to the receive status register.
// - two interrupt sources: receive holding full and transmit holding empty.
// - transmit event maps to priority line 1, receive event to line 0.
// - holding loads into shifter only after the previous word; tx_irq on full falling.
// - data words go out least significant bit first.
// - at stop bit store word, set full, raise rx_irq, flag overrun if unread.
// - echo output equals receive input xor both pad invert bits.
package uasp_pkg;
	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [2:0] ADDR_CTRL = 3'h0;
	localparam logic [2:0] ADDR_FMT = 3'h1;
	localparam logic [2:0] ADDR_TXH = 3'h2;
	localparam logic [2:0] ADDR_TXS = 3'h3;
	localparam logic [2:0] ADDR_RXH = 3'h4;
	localparam logic [2:0] ADDR_RXS = 3'h5;
	// ----------------------------------------
	// field positions and reset values
	// ----------------------------------------
	localparam int CTRL_ECHO = 7;
	localparam int CTRL_RXEN = 6;
	localparam int CTRL_TXEN = 5;
	localparam int CTRL_RXINV = 4;
	localparam int CTRL_TXINV = 3;
	localparam int FMT_XTAL = 7;
	localparam int FMT_ODD = 2;
	localparam int FMT_PE = 1;
	localparam int FMT_WL8 = 0;
	localparam logic [7:0] CTRL_RST = 8'h05;
	localparam logic [7:0] FMT_RST = 8'h01;
	localparam logic [7:0] FMT_MASK = 8'hbf;
	// ----------------------------------------
	// baud counts in source ticks per bit
	// ----------------------------------------
	localparam logic [19:0] RC_BIT_TICKS = 20'h00010;
	localparam logic [19:0] EXT_BIT_TICKS = 20'h00020;
	localparam logic [19:0] XTAL_BIT_TICKS = 20'h0000e;
	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [2:0] {
		SER_IDLE = 3'h0,
		SER_START = 3'h1,
		SER_DATA = 3'h3,
		SER_PAR = 3'h2,
		SER_STOP = 3'h6
	} uasp_ser_t;
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} uasp_bus_t;
	typedef struct packed {
		logic [7:0] line_control;
		logic [7:0] frame_format;
		logic [7:0] tx_hold;
		logic tx_full;
		uasp_ser_t tx_state;
		logic [7:0] tx_shift;
		logic tx_par;
		logic [2:0] tx_bits;
		logic [19:0] tx_cnt;
		logic tx_line;
		logic tx_irq;
		logic tx_pin;
		uasp_ser_t rx_state;
		logic [7:0] rx_shift;
		logic rx_par;
		logic [2:0] rx_bits;
		logic [19:0] rx_cnt;
		logic rx_serr;
		logic [7:0] rx_hold;
		logic rx_full;
		logic start_err;
		logic parity_err;
		logic frame_err;
		logic overrun_err;
		logic rx_irq;
		logic rx_s1;
		logic rx_s2;
		logic rx_prev;
		logic [7:0] rdata;
	} uasp_state_t;
endpackage

/* File: uasp_top.sv */
`timescale 1ns/1ps
module uasp_top (
	// clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// register port
	input wire uasp_pkg::uasp_bus_t bus,
	output logic [7:0] rdata,
	// baud sources, one-cycle enables
	input wire logic rc_tick,
	input wire logic ext_tick,
	input wire logic xtal_tick,
	input wire logic ext_clock_sel,
	// serial pads
	input wire logic rx_pin,
	output logic tx_pin,
	// interrupt manager, high priority lines 1 and 0
	output logic tx_irq,
	output logic rx_irq
);
	uasp_pkg::uasp_state_t q;
	uasp_pkg::uasp_state_t n;
	logic rx_in;
	logic src_tick;
	logic tx_exp;
	logic rx_exp;
	logic [19:0] period;
	logic [2:0] last_bit;
	logic wr_txh;
	logic rd_rxh;
	logic rx_done;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [19:0] bit_period(input logic [7:0] fmt, input logic ext, input logic [2:0] br);
		logic [4:0] sh;
		logic [19:0] base;
		sh = 5'h00;
		base = uasp_pkg::RC_BIT_TICKS;
		if (fmt[uasp_pkg::FMT_XTAL]) begin
			base = uasp_pkg::XTAL_BIT_TICKS;
			sh = (br > 3'h3) ? 5'h00 : {2'b00, 3'h3 - br};
		end else begin
			base = ext ? uasp_pkg::EXT_BIT_TICKS : uasp_pkg::RC_BIT_TICKS;
			sh = {2'b00, 3'h7 - br} + {2'b00, fmt[5:3]};
		end
		bit_period = base << sh;
	endfunction

	function automatic logic parity_of(input logic [7:0] d, input logic [7:0] fmt);
		logic p;
		p = ^d[6:0];
		if (fmt[uasp_pkg::FMT_WL8]) begin
			p = p ^ d[7];
		end
		parity_of = p ^ fmt[uasp_pkg::FMT_ODD];
	endfunction

	// ----------------------------------------
	// baud source and shared decode
	// ----------------------------------------
	// source selection
	assign src_tick = q.frame_format[uasp_pkg::FMT_XTAL] ? xtal_tick : (ext_clock_sel ? ext_tick : rc_tick);
	// bit length from baud_sel and prescaler
	assign period = bit_period(q.frame_format, ext_clock_sel, q.line_control[2:0]);
	assign last_bit = q.frame_format[uasp_pkg::FMT_WL8] ? 3'h7 : 3'h6;
	assign rx_in = q.rx_s2 ^ q.line_control[uasp_pkg::CTRL_RXINV];
	assign tx_exp = src_tick && (q.tx_cnt <= 20'h00001);
	assign rx_exp = src_tick && (q.rx_cnt <= 20'h00001);
	assign wr_txh = bus.wr && (bus.addr == uasp_pkg::ADDR_TXH);
	assign rd_rxh = bus.rd && (bus.addr == uasp_pkg::ADDR_RXH);
	assign rx_done = rx_exp && (q.rx_state == uasp_pkg::SER_STOP) && q.line_control[uasp_pkg::CTRL_RXEN];

	always_comb begin
		n = q;
		n.tx_irq = 1'b0;
		n.rx_irq = 1'b0;
		n.rdata = 8'h00;
		n.rx_s1 = rx_pin;
		n.rx_s2 = q.rx_s1;
		n.rx_prev = rx_in;

		// ----------------------------------------
		// register writes
		// ----------------------------------------
		if (bus.wr) begin
			case (bus.addr)
				uasp_pkg::ADDR_CTRL: begin
					n.line_control = bus.wdata;
				end
				uasp_pkg::ADDR_FMT: begin
					n.frame_format = bus.wdata & uasp_pkg::FMT_MASK;
				end
				uasp_pkg::ADDR_TXH: begin
					n.tx_hold = bus.wdata;
				end
				uasp_pkg::ADDR_RXS: begin
					n.overrun_err = 1'b0;
				end
				default: begin
				end
			endcase
		end

		// ----------------------------------------
		// register reads
		// ----------------------------------------
		if (bus.rd) begin
			case (bus.addr)
				uasp_pkg::ADDR_CTRL: begin
					n.rdata = q.line_control;
				end
				uasp_pkg::ADDR_FMT: begin
					n.rdata = q.frame_format;
				end
				uasp_pkg::ADDR_TXH: begin
					n.rdata = q.tx_hold;
				end
				uasp_pkg::ADDR_TXS: begin
					n.rdata = {6'h00, q.tx_state != uasp_pkg::SER_IDLE, q.tx_full};
				end
				uasp_pkg::ADDR_RXH: begin
					n.rdata = q.rx_hold;
				end
				uasp_pkg::ADDR_RXS: begin
					n.rdata = {2'b00, q.start_err, q.parity_err, q.frame_err, q.overrun_err,
						q.rx_state != uasp_pkg::SER_IDLE, q.rx_full};
				end
				default: begin
					n.rdata = 8'h00;
				end
			endcase
		end
		// reading data empties the holding register
		if (rd_rxh) begin
			n.rx_full = 1'b0;
		end

		// ----------------------------------------
		// transmitter
		// ----------------------------------------
		if (src_tick && !tx_exp) begin
			n.tx_cnt = q.tx_cnt - 20'h00001;
		end
		if (tx_exp) begin
			n.tx_cnt = period;
		end
		case (q.tx_state)
			uasp_pkg::SER_IDLE: begin
				n.tx_line = 1'b1;
				// load only when the shifter is free
				if (q.tx_full && q.line_control[uasp_pkg::CTRL_TXEN]) begin
					n.tx_shift = q.tx_hold;
					n.tx_par = parity_of(q.tx_hold, q.frame_format);
					n.tx_full = 1'b0;
					n.tx_irq = 1'b1;
					n.tx_bits = 3'h0;
					n.tx_cnt = period;
					n.tx_line = 1'b0;
					n.tx_state = uasp_pkg::SER_START;
				end
			end
			uasp_pkg::SER_START: begin
				if (tx_exp) begin
					n.tx_line = q.tx_shift[0];
					n.tx_state = uasp_pkg::SER_DATA;
				end
			end
			uasp_pkg::SER_DATA: begin
				if (tx_exp) begin
					n.tx_shift = {1'b0, q.tx_shift[7:1]};
					n.tx_bits = q.tx_bits + 3'h1;
					n.tx_line = q.tx_shift[1];
					if (q.tx_bits == last_bit) begin
						if (q.frame_format[uasp_pkg::FMT_PE]) begin
							n.tx_line = q.tx_par;
							n.tx_state = uasp_pkg::SER_PAR;
						end else begin
							n.tx_line = 1'b1;
							n.tx_state = uasp_pkg::SER_STOP;
						end
					end
				end
			end
			uasp_pkg::SER_PAR: begin
				if (tx_exp) begin
					n.tx_line = 1'b1;
					n.tx_state = uasp_pkg::SER_STOP;
				end
			end
			uasp_pkg::SER_STOP: begin
				if (tx_exp) begin
					n.tx_state = uasp_pkg::SER_IDLE;
				end
			end
			default: begin
				n.tx_state = uasp_pkg::SER_IDLE;
			end
		endcase
		if (!q.line_control[uasp_pkg::CTRL_TXEN]) begin
			n.tx_state = uasp_pkg::SER_IDLE;
			n.tx_line = 1'b1;
		end
		// a write refills the holding register, winning over the load
		if (wr_txh) begin
			n.tx_full = 1'b1;
		end
		if (q.line_control[uasp_pkg::CTRL_ECHO]) begin
			n.tx_pin = q.rx_s2 ^ q.line_control[uasp_pkg::CTRL_RXINV] ^ q.line_control[uasp_pkg::CTRL_TXINV];
		end else begin
			n.tx_pin = n.tx_line ^ q.line_control[uasp_pkg::CTRL_TXINV];
		end

		// ----------------------------------------
		// receiver
		// ----------------------------------------
		if (src_tick && !rx_exp) begin
			n.rx_cnt = q.rx_cnt - 20'h00001;
		end
		if (rx_exp) begin
			n.rx_cnt = period;
		end
		case (q.rx_state)
			uasp_pkg::SER_IDLE: begin
				if (q.line_control[uasp_pkg::CTRL_RXEN] && q.rx_prev && !rx_in) begin
					n.rx_cnt = {1'b0, period[19:1]};
					n.rx_bits = 3'h0;
					n.rx_state = uasp_pkg::SER_START;
				end
			end
			uasp_pkg::SER_START: begin
				if (rx_exp) begin
					n.rx_serr = rx_in;
					n.rx_state = uasp_pkg::SER_DATA;
				end
			end
			uasp_pkg::SER_DATA: begin
				if (rx_exp) begin
					n.rx_shift = {rx_in, q.rx_shift[7:1]};
					n.rx_bits = q.rx_bits + 3'h1;
					if (q.rx_bits == last_bit) begin
						n.rx_state = q.frame_format[uasp_pkg::FMT_PE] ? uasp_pkg::SER_PAR : uasp_pkg::SER_STOP;
					end
				end
			end
			uasp_pkg::SER_PAR: begin
				if (rx_exp) begin
					n.rx_par = rx_in;
					n.rx_state = uasp_pkg::SER_STOP;
				end
			end
			uasp_pkg::SER_STOP: begin
				if (rx_exp) begin
					n.rx_state = uasp_pkg::SER_IDLE;
				end
			end
			default: begin
				n.rx_state = uasp_pkg::SER_IDLE;
			end
		endcase
		// store at stop bit, flag unread word
		if (rx_done) begin
			n.rx_hold = q.frame_format[uasp_pkg::FMT_WL8] ? q.rx_shift : {1'b0, q.rx_shift[7:1]};
			n.overrun_err = q.overrun_err | (q.rx_full & !rd_rxh);
			n.rx_full = 1'b1;
			n.rx_irq = 1'b1;
			n.start_err = q.rx_serr;
			n.frame_err = !rx_in;
			n.parity_err = q.frame_format[uasp_pkg::FMT_PE] &&
				(q.rx_par != parity_of(n.rx_hold, q.frame_format));
		end
		if (!q.line_control[uasp_pkg::CTRL_RXEN]) begin
			n.rx_state = uasp_pkg::SER_IDLE;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			q <= '0;
			q.line_control <= uasp_pkg::CTRL_RST;
			q.frame_format <= uasp_pkg::FMT_RST;
			q.tx_line <= 1'b1;
			q.tx_pin <= 1'b1;
			q.rx_s1 <= 1'b1;
			q.rx_s2 <= 1'b1;
		end else begin
			q <= n;
		end
	end

	assign rdata = q.rdata;
	assign tx_pin = q.tx_pin;
	assign tx_irq = q.tx_irq;
	assign rx_irq = q.rx_irq;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!resetn);

	txfull_set_a: assert property (wr_txh |=> q.tx_full) else $error("holding write did not set full");
	txirq_fall_a: assert property (q.tx_irq |-> $past(q.tx_full) && $past(q.tx_state) == uasp_pkg::SER_IDLE)
		else $error("transmit event without holding emptying");
	rxfull_clr_a: assert property (rd_rxh && !rx_done |=> !q.rx_full) else $error("data read left full set");
	overrun_set_a: assert property (rx_done && q.rx_full && !rd_rxh |=> q.overrun_err && q.rx_irq)
		else $error("unread word gave no overrun");
	ovr_clear_a: assert property (bus.wr && bus.addr == uasp_pkg::ADDR_RXS && !rx_done |=> !q.overrun_err)
		else $error("status write did not clear overrun");
	tx_disable_a: assert property (!q.line_control[uasp_pkg::CTRL_TXEN] |=> q.tx_state == uasp_pkg::SER_IDLE)
		else $error("transmitter ran while disabled");
	echo_path_a: assert property (q.line_control[uasp_pkg::CTRL_ECHO] |=>
		tx_pin == ($past(q.rx_s2) ^ $past(q.line_control[4]) ^ $past(q.line_control[3])))
		else $error("echo output wrong");
	start_low_a: assert property ($rose(q.tx_state == uasp_pkg::SER_START) |-> !q.tx_line ##1 !q.tx_line)
		else $error("start bit not low");
	rx_store_a: assert property (rx_done |=> q.rx_full && q.rx_irq)
		else $error("stop bit did not store the word");
	rxirq_src_a: assert property (q.rx_irq |-> $past(rx_done))
		else $error("receive event without a stored word");
	rx_disable_a: assert property (!q.line_control[uasp_pkg::CTRL_RXEN] |=> q.rx_state == uasp_pkg::SER_IDLE)
		else $error("receiver ran while disabled");
	tx_load_a: assert property (q.tx_state == uasp_pkg::SER_IDLE && q.tx_full && !wr_txh
		&& q.line_control[uasp_pkg::CTRL_TXEN] |=> !q.tx_full && q.tx_irq)
		else $error("full holding not loaded into idle shifter");
	stop_high_a: assert property (q.tx_state == uasp_pkg::SER_STOP |-> q.tx_line)
		else $error("stop bit not high");
endmodule

/* File: uasp_remote.sv */
`timescale 1ns/1ps
module uasp_remote (
	// clock
	input wire logic mclk,
	// serial lines, named from the device side
	input wire logic tx_pin,
	output logic rx_pin
);
	initial rx_pin = 1'h1;
	// ------
	// line driving
	// ------
	// start, data lsb first, stop
	task automatic send(input logic [10:0] f, input int n, input int p);
		for (int i = 0; i < n; i++) begin
			rx_pin <= f[i];
			repeat (p) @(posedge mclk);
		end
		rx_pin <= 1'h1;
	endtask
	task automatic level(input logic v);
		rx_pin <= v;
	endtask
	// ------
	// frame capture, mid-bit sampling
	// ------
	task automatic recv(output logic [10:0] f, input int n, input int p);
		int t;
		f = '0;
		t = 0;
		do begin
			@(negedge mclk);
			t++;
		end while (tx_pin !== 1'h0 && t < 4000);
		// no start bit: unknowns make the compare fail
		if (tx_pin !== 1'h0) begin
			f = 'x;
		end else begin
			repeat (p / 2) @(negedge mclk);
			for (int i = 0; i < n; i++) begin
				if (i > 0) repeat (p) @(negedge mclk);
				f[i] = tx_pin;
			end
		end
		@(posedge mclk);
	endtask
endmodule

/* File: uasp_top_tb.sv */
`timescale 1ns/1ps
module uasp_top_tb;
	logic mclk;
	logic resetn;
	uasp_pkg::uasp_bus_t bus;
	logic [7:0] rdata;
	logic rc_tick;
	logic ext_tick;
	logic xtal_tick;
	logic ext_clock_sel;
	logic rx_pin;
	logic tx_pin;
	logic tx_irq;
	logic rx_irq;
	int err_count;
	int n_checks;
	uasp_top dut (.mclk(mclk), .resetn(resetn), .bus(bus), .rdata(rdata), .rc_tick(rc_tick),
		.ext_tick(ext_tick), .xtal_tick(xtal_tick), .ext_clock_sel(ext_clock_sel),
		.rx_pin(rx_pin), .tx_pin(tx_pin), .tx_irq(tx_irq), .rx_irq(rx_irq));
	uasp_remote remote (.mclk(mclk), .tx_pin(tx_pin), .rx_pin(rx_pin));
	always #12.5 mclk = ~mclk;
	// crystal ticks every second cycle
	always @(posedge mclk) xtal_tick <= ~xtal_tick;
	// ------
	// helpers
	// ------
	task automatic finish_test();
		if (err_count == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [10:0] got, input logic [10:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic do_reset();
		resetn <= 1'h0;
		repeat (20) @(posedge mclk);
		resetn <= 1'h1;
		@(posedge mclk);
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		bus <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
		@(posedge mclk);
		bus.wr <= 1'h0;
		@(posedge mclk);
	endtask
	task automatic rchk(input logic [2:0] a, input logic [7:0] e);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
		@(posedge mclk);
		bus.rd <= 1'h0;
		@(negedge mclk);
		chk({3'h0, rdata}, {3'h0, e});
		@(posedge mclk);
	endtask
	task automatic wait_irq(input bit rx);
		int t;
		t = 0;
		do begin
			@(negedge mclk);
			t++;
		end while ((rx ? rx_irq : tx_irq) !== 1'h1 && t < 4000);
		if ((rx ? rx_irq : tx_irq) !== 1'h1) begin
			err_count++;
			finish_test();
		end
		@(posedge mclk);
	endtask
	task automatic wait_pin(input logic e);
		for (int t = 0; t < 8; t++) begin
			@(negedge mclk);
			if (tx_pin === e) break;
		end
		chk({10'h0, tx_pin}, {10'h0, e});
		@(posedge mclk);
	endtask
	task automatic rx_frame(input logic [10:0] f);
		fork
			remote.send(f, 10, 16);
			wait_irq(1'h1);
		join
	endtask
	// ------
	// scenarios
	// ------
	task automatic t_regs();
		logic [7:0] e [0:6] = '{8'h05, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		for (int a = 0; a < 7; a++) rchk(3'(a), e[a]);
		wr(uasp_pkg::ADDR_FMT, 8'hff);
		rchk(uasp_pkg::ADDR_FMT, 8'hbf);
		wr(3'h6, 8'hff);
		rchk(3'h6, 8'h00);
		wr(uasp_pkg::ADDR_TXH, 8'h55);
		rchk(uasp_pkg::ADDR_TXS, 8'h01);
		rchk(uasp_pkg::ADDR_TXH, 8'h55);
		chk({10'h0, tx_pin}, 11'h001);
	endtask
	task automatic t_tx();
		logic [10:0] f1;
		logic [10:0] f2;
		wr(uasp_pkg::ADDR_CTRL, 8'h27);
		fork
			begin
				remote.recv(f1, 10, 16);
				remote.recv(f2, 10, 16);
			end
			begin
				wr(uasp_pkg::ADDR_TXH, 8'h4b);
				wait_irq(1'h0);
				wr(uasp_pkg::ADDR_TXH, 8'hd2);
				rchk(uasp_pkg::ADDR_TXS, 8'h03);
				wait_irq(1'h0);
			end
		join
		chk(f1, {2'h1, 8'h4b, 1'h0});
		chk(f2, {2'h1, 8'hd2, 1'h0});
	endtask
	task automatic t_par();
		logic [10:0] f;
		logic [6:0] d;
		ext_clock_sel <= 1'h1;
		wr(uasp_pkg::ADDR_CTRL, 8'h26);
		for (int o = 0; o < 2; o++) begin
			d = 7'h35 + 7'(o);
			wr(uasp_pkg::ADDR_FMT, {5'h00, 1'(o), 2'h2});
			fork
				remote.recv(f, 10, 64);
				wr(uasp_pkg::ADDR_TXH, {1'h0, d});
			join
			chk(f, {2'h1, ^d ^ 1'(o), d, 1'h0});
		end
		ext_clock_sel <= 1'h0;
		wr(uasp_pkg::ADDR_FMT, 8'h81);
		fork
			remote.recv(f, 10, 28);
			wr(uasp_pkg::ADDR_TXH, 8'ha6);
		join
		chk(f, {2'h1, 8'ha6, 1'h0});
		wr(uasp_pkg::ADDR_FMT, 8'h01);
	endtask
	task automatic t_rx();
		wr(uasp_pkg::ADDR_CTRL, 8'h47);
		rx_frame({2'h1, 8'h3c, 1'h0});
		rchk(uasp_pkg::ADDR_RXS, 8'h01);
		rchk(uasp_pkg::ADDR_RXH, 8'h3c);
		rchk(uasp_pkg::ADDR_RXS, 8'h00);
		rx_frame({2'h1, 8'h81, 1'h0});
		rx_frame({2'h1, 8'h7e, 1'h0});
		rchk(uasp_pkg::ADDR_RXS, 8'h05);
		wr(uasp_pkg::ADDR_RXS, 8'h00);
		rchk(uasp_pkg::ADDR_RXS, 8'h01);
		rchk(uasp_pkg::ADDR_RXH, 8'h7e);
		wr(uasp_pkg::ADDR_FMT, 8'h02);
		rx_frame({2'h1, 1'h0, 7'h01, 1'h0});
		rchk(uasp_pkg::ADDR_RXS, 8'h11);
		rchk(uasp_pkg::ADDR_RXH, 8'h01);
		wr(uasp_pkg::ADDR_FMT, 8'h01);
		rx_frame({2'h0, 8'h5a, 1'h0});
		rchk(uasp_pkg::ADDR_RXS, 8'h09);
	endtask
	task automatic t_echo();
		wr(uasp_pkg::ADDR_CTRL, 8'h0f);
		wait_pin(1'h0);
		for (int i = 0; i < 4; i++) begin
			wr(uasp_pkg::ADDR_CTRL, {3'h4, 2'(i), 3'h7});
			for (int v = 0; v < 2; v++) begin
				remote.level(1'(v));
				wait_pin(1'(v) ^ 1'(i) ^ 1'(i >> 1));
			end
		end
	endtask
	initial begin
		mclk = 1'h0;
		resetn = 1'h0;
		bus = '0;
		rc_tick = 1'h1;
		ext_tick = 1'h1;
		xtal_tick = 1'h0;
		ext_clock_sel = 1'h0;
		err_count = 0;
		n_checks = 0;
		do_reset();
		t_regs();
		do_reset();
		t_tx();
		t_par();
		t_rx();
		t_echo();
		finish_test();
	end
endmodule
